/* File: src/core_alu.sv */
module core_alu import core_pkg::*; (
	input  wire alu_op_t    op,        // operation
	input  wire logic [7:0] a,         // destination operand
	input  wire logic [7:0] b,         // source operand or immediate
	input  wire flags_t     flags_in,  // current flags
	output logic [7:0]      result,    // result byte
	output flags_t          flags_out  // updated flags
);
	logic [8:0] wide;
	logic       cin;

	always_comb begin
		wide      = 9'h000;
		cin       = flags_in.wrap;
		result    = 8'h00;
		flags_out = flags_in;
		unique case (op)
			ALU_ADD, ALU_ADC: begin
				wide             = {1'b0, a} + {1'b0, b} + {8'h00, (op == ALU_ADC) & cin};
				result           = wide[7:0];
				flags_out.wrap   = wide[8]; // RULE21
				flags_out.nibble = (a[3] & b[3]) | (b[3] & ~result[3]) | (~result[3] & a[3]); // RULE16 RULE23
				flags_out.twoc   = (a[7] & b[7] & ~result[7]) | (~a[7] & ~b[7] & result[7]); // RULE18
			end
			ALU_SUB, ALU_SBC: begin
				wide             = {1'b0, a} - {1'b0, b} - {8'h00, (op == ALU_SBC) & cin};
				result           = wide[7:0];
				flags_out.wrap   = wide[8]; // RULE21
				flags_out.nibble = (~a[3] & b[3]) | (b[3] & result[3]) | (result[3] & ~a[3]); // RULE16
				flags_out.twoc   = (a[7] & ~b[7] & ~result[7]) | (~a[7] & b[7] & result[7]); // RULE18
			end
			ALU_AND, ALU_OR, ALU_EOR: begin
				result         = (op == ALU_AND) ? (a & b) : (op == ALU_OR) ? (a | b) : (a ^ b);
				flags_out.twoc = 1'b0;
			end
			ALU_COM: begin
				result         = ~a;
				flags_out.wrap = 1'b1;
				flags_out.twoc = 1'b0;
			end
			ALU_NEG: begin
				result           = 8'h00 - a;
				flags_out.wrap   = (result != 8'h00);
				flags_out.twoc   = (result == 8'h80);
				flags_out.nibble = result[3] | a[3];
			end
			ALU_INC: begin
				result         = a + 8'h01;
				flags_out.twoc = (result == 8'h80);
			end
			ALU_DEC: begin
				result         = a - 8'h01;
				flags_out.twoc = (result == 8'h7f);
			end
			ALU_LSR, ALU_ROR, ALU_ASR: begin
				result         = {(op == ALU_LSR) ? 1'b0 : (op == ALU_ROR) ? cin : a[7], a[7:1]};
				flags_out.wrap = a[0];
				flags_out.twoc = result[7] ^ a[0];
			end
			ALU_SWAP: begin
				result = {a[3:0], a[7:4]};
			end
		endcase
		if (op != ALU_SWAP) begin
			flags_out.top      = result[7]; // RULE19
			flags_out.zero     = (result == 8'h00) & ((op != ALU_SBC) | flags_in.zero); // RULE20
			flags_out.polarity = flags_out.top ^ flags_out.twoc; // RULE17
		end
	end
endmodule : core_alu

/* File: src/core_pkg.sv */
package core_pkg;
	localparam int          NUM_REGS     = 32;
	localparam int          NUM_IRQ      = 8;
	localparam logic [15:0] DS_IO_FIRST  = 16'h0020;
	localparam logic [15:0] DS_IO_LAST   = 16'h005f;
	localparam logic [15:0] DS_EXT_FIRST = 16'h0060;
	localparam logic [15:0] DS_EXT_LAST  = 16'h00ff;
	localparam logic [5:0]  IO_FLAGS     = 6'h3f;
	localparam logic [5:0]  IO_STACK_LO  = 6'h3d;
	localparam logic [5:0]  IO_STACK_HI  = 6'h3e;
	localparam logic [7:0]  FLAGS_RESET  = 8'h00;
	localparam logic [15:0] STACK_RESET  = 16'h04ff;
	localparam logic [15:0] FETCH_RESET  = 16'h0000;
	localparam logic [15:0] VEC_BASE     = 16'h0000;
	localparam logic [15:0] VEC_STRIDE   = 16'h0002;
	localparam logic [4:0]  PTR_X        = 5'h1a;
	localparam logic [4:0]  PTR_Z        = 5'h1e;
	localparam logic [4:0]  PTR_BASE     = 5'h18;
	// major opcodes, instruction bits 15:12
	localparam logic [3:0]  OP_MISC = 4'h0;
	localparam logic [3:0]  OP_ADD  = 4'h1;
	localparam logic [3:0]  OP_ADC  = 4'h2;
	localparam logic [3:0]  OP_SUB  = 4'h3;
	localparam logic [3:0]  OP_SBC  = 4'h4;
	localparam logic [3:0]  OP_AND  = 4'h5;
	localparam logic [3:0]  OP_OR   = 4'h6;
	localparam logic [3:0]  OP_EOR  = 4'h7;
	localparam logic [3:0]  OP_MOV  = 4'h8;
	localparam logic [3:0]  OP_CP   = 4'h9;
	localparam logic [3:0]  OP_SUBI = 4'ha;
	localparam logic [3:0]  OP_ANDI = 4'hb;
	localparam logic [3:0]  OP_ORI  = 4'hc;
	localparam logic [3:0]  OP_LDI  = 4'hd;
	localparam logic [3:0]  OP_FLOW = 4'he;
	localparam logic [3:0]  OP_IO   = 4'hf;
	// misc sub-opcodes, instruction bits 11:8
	localparam logic [3:0]  SUB_NOP    = 4'h0;
	localparam logic [3:0]  SUB_GIE_ON = 4'h1;
	localparam logic [3:0]  SUB_GIE_OFF= 4'h2;
	localparam logic [3:0]  SUB_RET    = 4'h3;
	localparam logic [3:0]  SUB_IRET   = 4'h4;
	localparam logic [3:0]  SUB_JMP    = 4'h5;
	localparam logic [3:0]  SUB_CALL   = 4'h6;
	localparam logic [3:0]  SUB_LDS    = 4'h7;
	localparam logic [3:0]  SUB_STS    = 4'h8;
	localparam logic [3:0]  SUB_LPM    = 4'h9;
	localparam logic [3:0]  SUB_TSTORE = 4'ha;
	localparam logic [3:0]  SUB_TLOAD  = 4'hb;
	localparam logic [3:0]  SUB_UNARY  = 4'hc;
	localparam logic [3:0]  SUB_LDP    = 4'hd;
	localparam logic [3:0]  SUB_STP    = 4'he;

	typedef struct packed {
		logic gie;      // bit 7
		logic copy;     // bit 6
		logic nibble;   // bit 5
		logic polarity; // bit 4
		logic twoc;     // bit 3
		logic top;      // bit 2
		logic zero;     // bit 1
		logic wrap;     // bit 0
	} flags_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} bus_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} io_t;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_COM,
		ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ROR, ALU_ASR, ALU_SWAP
	} alu_op_t;

	typedef enum logic [3:0] {
		ST_EXEC, ST_WORD2, ST_PUSH, ST_JUMP, ST_POP1, ST_POP2, ST_POP3,
		ST_LPM, ST_LPM2, ST_LOAD_A, ST_LOAD_B
	} state_t;
endpackage : core_pkg

/* File: src/core_top.sv */
// How it works
// RULE1: prefetch next word while current executes
// RULE2: thirty-two 8-bit registers, single-cycle access
// RULE3: read two operands, write result same cycle
// RULE4: three 16-bit pointers; one reads program memory
// RULE5: register, immediate and single-register ALU operations
// RULE6: flags updated after every ALU operation
// RULE7: status never saved or restored on interrupts
// RULE8: decoder accepts one-word and two-word instructions
// RULE9: lowest pending vector is served first
// RULE10: 64 I/O addresses, also data 0x20-0x5F
// RULE11: 0x60-0xFF reachable only by data loads/stores
// RULE12: bit 7 gates every interrupt
// RULE13: accept clears bit 7; interrupt return sets it
// RULE14: dedicated ops set and clear bit 7
// RULE15: bit 6 copies register bits both ways
// RULE16: bit 5 flags half carry
// RULE17: bit 4 equals bit 2 xor bit 3
// RULE18: bit 3 flags two's complement overflow
// RULE19: bit 2 flags negative result
// RULE20: bit 1 flags zero result
// RULE21: bit 0 flags carry
// RULE22: return address pushed to data stack
// RULE23: additions: half carry from bit 3
// RULE24: status reads zero after reset
module core_top import core_pkg::*; (
	input  wire logic               core_clk,            // cpu clock
	input  wire logic               rstn,                // async reset, active low
	output logic [15:0]             prog_addr,           // program word address
	input  wire logic [15:0]        prog_data,           // word of address seen at previous edge
	output bus_t                    data_bus,            // data space access from 0x60 up
	input  wire logic [7:0]         data_rdata,          // read data, cycle after re
	output io_t                     io_bus,              // external i/o access
	input  wire logic [7:0]         io_rdata,            // i/o read data, cycle after re
	input  wire logic [NUM_IRQ-1:0] irq_req,             // pending interrupt levels
	output logic                    irq_ack,             // interrupt accepted pulse
	output logic [2:0]              irq_ack_id,          // accepted interrupt index
	output flags_t                  alu_condition_flags, // status register
	output logic [15:0]             stack_top_ptr        // stack pointer
);
	logic [7:0]  regs_q [NUM_REGS];
	flags_t      flags_q, flags_d, alu_flags;
	state_t      state_q, state_d;
	logic [15:0] fetch_address_q, fetch_address_d, stack_top_ptr_q, stack_top_ptr_d;
	logic [15:0] hold_q, hold_d, target_q, target_d, ret_q, ret_d;
	logic [7:0]  pop_hi_q, pop_hi_d;
	logic [4:0]  ld_reg_q, ld_reg_d;
	logic        valid_q, valid_d, ld_io_q, ld_io_d, iret_q, iret_d, lpm_lo_q, lpm_lo_d;
	bus_t        bus_q, bus_d;
	io_t         io_q, io_d;
	logic        ack_q, ack_d;
	logic [2:0]  ack_id_q, ack_id_d;

	logic [15:0] w, ptr_val, irq_vec;
	logic [3:0]  op, sub;
	logic [4:0]  rd, rr, rdi, dst, ptr_idx, wr_idx, acc_reg, ptr_wr_idx;
	logic [7:0]  imm, alu_a, alu_b, alu_res, wr_data;
	logic [2:0]  irq_idx;
	logic        irq_take, wr_en, ptr_en, acc_rd, acc_wr, use_alu;
	logic [15:0] acc_addr, ptr_wr_val;
	logic [5:0]  ioa;
	alu_op_t     alu_op;

	// active instruction word: held first word while the second is on the bus
	assign w     = (state_q == ST_WORD2) ? hold_q : prog_data; // RULE8
	assign op    = w[15:12];
	assign sub   = w[11:8];
	assign rd    = w[4:0];
	assign rr    = w[9:5];
	assign rdi   = {1'b1, w[7:4]};
	assign imm   = {w[11:8], w[3:0]};
	assign ptr_idx = (w[6:5] == 2'b00) ? PTR_X : PTR_BASE + 5'({w[6:5], 1'b0}); // RULE4
	assign ptr_val = {regs_q[{ptr_idx[4:1], 1'b1}], regs_q[ptr_idx]};

	assign prog_addr           = (state_q == ST_LPM) ? {1'b0, regs_q[PTR_Z + 5'h01], regs_q[PTR_Z][7:1]}
	                                                 : fetch_address_q; // RULE1 RULE4
	assign data_bus            = bus_q;
	assign io_bus              = io_q;
	assign irq_ack             = ack_q;
	assign irq_ack_id          = ack_id_q;
	assign alu_condition_flags = flags_q;
	assign stack_top_ptr       = stack_top_ptr_q;

	// operand selection and alu operation
	always_comb begin
		alu_op  = ALU_ADD;
		dst     = rd;
		alu_b   = regs_q[rr];
		use_alu = 1'b1;
		unique case (op)
			OP_ADD:  alu_op = ALU_ADD;
			OP_ADC:  alu_op = ALU_ADC;
			OP_SUB, OP_CP: alu_op = ALU_SUB;
			OP_SBC:  alu_op = ALU_SBC;
			OP_AND:  alu_op = ALU_AND;
			OP_OR:   alu_op = ALU_OR;
			OP_EOR:  alu_op = ALU_EOR;
			OP_MOV:  use_alu = 1'b0;
			OP_SUBI, OP_ANDI, OP_ORI, OP_LDI: begin // RULE5
				dst     = rdi;
				alu_b   = imm;
				alu_op  = (op == OP_SUBI) ? ALU_SUB : (op == OP_ANDI) ? ALU_AND : ALU_OR;
				use_alu = (op != OP_LDI);
			end
			OP_MISC: begin
				unique case (w[7:5])
					3'h0: alu_op = ALU_COM;
					3'h1: alu_op = ALU_NEG;
					3'h2: alu_op = ALU_INC;
					3'h3: alu_op = ALU_DEC;
					3'h4: alu_op = ALU_LSR;
					3'h5: alu_op = ALU_ROR;
					3'h6: alu_op = ALU_ASR;
					3'h7: alu_op = ALU_SWAP;
				endcase
			end
			default: use_alu = 1'b0;
		endcase
		alu_a = regs_q[dst]; // RULE3
	end

	core_alu u_alu (
		.op        (alu_op),
		.a         (alu_a),
		.b         (alu_b),
		.flags_in  (flags_q),
		.result    (alu_res),
		.flags_out (alu_flags)
	);

	// lowest index, hence lowest vector address, wins
	always_comb begin
		irq_idx = 3'h0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (irq_req[i]) begin
				irq_idx = 3'(i); // RULE9
			end
		end
		irq_vec  = VEC_BASE + VEC_STRIDE * ({13'h0000, irq_idx} + 16'h0001); // RULE9
		irq_take = valid_q && flags_q.gie && (|irq_req); // RULE12
	end

	// sequencing, register writes and data space accesses
	always_comb begin
		state_d         = state_q;
		fetch_address_d = fetch_address_q;
		valid_d         = valid_q;
		flags_d         = flags_q;
		stack_top_ptr_d = stack_top_ptr_q;
		hold_d          = hold_q;
		target_d        = target_q;
		ret_d           = ret_q;
		pop_hi_d        = pop_hi_q;
		ld_reg_d        = ld_reg_q;
		ld_io_d         = ld_io_q;
		iret_d          = iret_q;
		lpm_lo_d        = lpm_lo_q;
		bus_d           = '0;
		io_d            = '0;
		ack_d           = 1'b0;
		ack_id_d        = ack_id_q;
		wr_en           = 1'b0;
		wr_idx          = dst;
		wr_data         = alu_res;
		ptr_en          = 1'b0;
		ptr_wr_idx      = ptr_idx;
		ptr_wr_val      = ptr_val + 16'h0001;
		acc_rd          = 1'b0;
		acc_wr          = 1'b0;
		acc_addr        = ptr_val;
		acc_reg         = rd;
		ioa             = 6'h00;
		unique case (state_q)
			ST_EXEC: begin
				fetch_address_d = fetch_address_q + 16'h0001; // RULE1
				valid_d         = 1'b1;
				if (!valid_q) begin
					// bubble after a jump: discard the stale word
				end else if (irq_take) begin
					// only the return address is stacked, flags other than gie stay as they are
					flags_d.gie     = 1'b0; // RULE13 RULE7
					ack_d           = 1'b1;
					ack_id_d        = irq_idx;
					fetch_address_d = fetch_address_q;
					ret_d           = fetch_address_q - 16'h0001;
					target_d        = irq_vec;
					bus_d           = '{addr: stack_top_ptr_q, wdata: ret_d[7:0], we: 1'b1, re: 1'b0}; // RULE22
					stack_top_ptr_d = stack_top_ptr_q - 16'h0001;
					state_d         = ST_PUSH;
				end else begin
					unique case (op)
						OP_MISC: begin
							unique case (sub)
								SUB_NOP: ;
								SUB_GIE_ON:  flags_d.gie = 1'b1; // RULE14
								SUB_GIE_OFF: flags_d.gie = 1'b0; // RULE14
								SUB_RET, SUB_IRET: begin
									iret_d          = (sub == SUB_IRET);
									fetch_address_d = fetch_address_q;
									bus_d           = '{addr: stack_top_ptr_q + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
									stack_top_ptr_d = stack_top_ptr_q + 16'h0001;
									state_d         = ST_POP1;
								end
								SUB_JMP, SUB_CALL, SUB_LDS, SUB_STS: begin
									hold_d  = w; // RULE8
									state_d = ST_WORD2;
								end
								SUB_LPM: begin
									ld_reg_d        = rd;
									lpm_lo_d        = ~regs_q[PTR_Z][0];
									fetch_address_d = fetch_address_q;
									state_d         = ST_LPM;
								end
								SUB_TSTORE: flags_d.copy = regs_q[rd][w[7:5]]; // RULE15
								SUB_TLOAD: begin
									wr_en           = 1'b1;
									wr_idx          = rd;
									wr_data         = regs_q[rd];
									wr_data[w[7:5]] = flags_q.copy; // RULE15
								end
								SUB_UNARY: begin
									wr_en   = 1'b1; // RULE5
									flags_d = alu_flags; // RULE6
								end
								SUB_LDP, SUB_STP: begin
									acc_rd = (sub == SUB_LDP);
									acc_wr = (sub == SUB_STP);
									ptr_en = w[7]; // RULE4
								end
								default: ;
							endcase
						end
						OP_FLOW: begin
							if (!w[11]) begin
								fetch_address_d = fetch_address_q + {{5{w[10]}}, w[10:0]};
								valid_d         = 1'b0;
							end else if (flags_q[w[10:8]] == w[7]) begin // RULE6
								fetch_address_d = fetch_address_q + {{9{w[6]}}, w[6:0]};
								valid_d         = 1'b0;
							end
						end
						OP_IO: begin
							// six-bit address never reaches the extended window
							acc_addr = DS_IO_FIRST + {10'h000, w[10:5]}; // RULE10 RULE11
							acc_rd   = ~w[11];
							acc_wr   = w[11];
						end
						OP_MOV, OP_LDI: begin
							wr_en   = 1'b1;
							wr_data = alu_b;
						end
						default: begin
							wr_en   = (op != OP_CP); // RULE3
							flags_d = alu_flags; // RULE6
						end
					endcase
				end
			end
			ST_WORD2: begin
				state_d         = ST_EXEC;
				fetch_address_d = fetch_address_q + 16'h0001;
				valid_d         = 1'b1;
				unique case (sub)
					SUB_JMP: begin
						fetch_address_d = prog_data;
						valid_d         = 1'b0;
					end
					SUB_CALL: begin
						fetch_address_d = fetch_address_q;
						ret_d           = fetch_address_q;
						target_d        = prog_data;
						bus_d           = '{addr: stack_top_ptr_q, wdata: fetch_address_q[7:0], we: 1'b1, re: 1'b0}; // RULE22
						stack_top_ptr_d = stack_top_ptr_q - 16'h0001;
						state_d         = ST_PUSH;
					end
					SUB_LDS, SUB_STS: begin
						acc_addr = prog_data; // RULE11
						acc_rd   = (sub == SUB_LDS);
						acc_wr   = (sub == SUB_STS);
					end
					default: ;
				endcase
			end
			ST_PUSH: begin
				bus_d           = '{addr: stack_top_ptr_q, wdata: ret_q[15:8], we: 1'b1, re: 1'b0}; // RULE22
				stack_top_ptr_d = stack_top_ptr_q - 16'h0001;
				state_d         = ST_JUMP;
			end
			ST_JUMP: begin
				fetch_address_d = target_q;
				valid_d         = 1'b0;
				state_d         = ST_EXEC;
			end
			ST_POP1: begin
				bus_d           = '{addr: stack_top_ptr_q + 16'h0001, wdata: 8'h00, we: 1'b0, re: 1'b1};
				stack_top_ptr_d = stack_top_ptr_q + 16'h0001;
				state_d         = ST_POP2;
			end
			ST_POP2: begin
				pop_hi_d = data_rdata;
				state_d  = ST_POP3;
			end
			ST_POP3: begin
				fetch_address_d = {pop_hi_q, data_rdata};
				valid_d         = 1'b0;
				if (iret_q) begin
					flags_d.gie = 1'b1; // RULE13
				end
				state_d = ST_EXEC;
			end
			ST_LPM: state_d = ST_LPM2;
			ST_LPM2: begin
				wr_en           = 1'b1; // RULE4
				wr_idx          = ld_reg_q;
				wr_data         = lpm_lo_q ? prog_data[7:0] : prog_data[15:8];
				fetch_address_d = fetch_address_q + 16'h0001;
				state_d         = ST_EXEC;
			end
			ST_LOAD_A: state_d = ST_LOAD_B;
			ST_LOAD_B: begin
				wr_en           = 1'b1;
				wr_idx          = ld_reg_q;
				wr_data         = ld_io_q ? io_rdata : data_rdata;
				fetch_address_d = fetch_address_q + 16'h0001;
				state_d         = ST_EXEC;
			end
		endcase

		// data space decode: registers, i/o window, everything above
		if (acc_rd || acc_wr) begin
			ioa = 6'(acc_addr - DS_IO_FIRST);
			if (acc_addr < DS_IO_FIRST) begin
				wr_en   = 1'b1;
				wr_idx  = acc_wr ? acc_addr[4:0] : acc_reg;
				wr_data = acc_wr ? regs_q[acc_reg] : regs_q[acc_addr[4:0]];
			end else if (acc_addr <= DS_IO_LAST &&
			             (ioa == IO_FLAGS || ioa == IO_STACK_LO || ioa == IO_STACK_HI)) begin // RULE10
				if (acc_wr) begin
					unique case (ioa)
						IO_FLAGS:    flags_d = regs_q[acc_reg];
						IO_STACK_LO: stack_top_ptr_d[7:0] = regs_q[acc_reg];
						default:     stack_top_ptr_d[15:8] = regs_q[acc_reg];
					endcase
				end else begin
					wr_en   = 1'b1;
					wr_idx  = acc_reg;
					wr_data = (ioa == IO_FLAGS) ? flags_q :
					          (ioa == IO_STACK_LO) ? stack_top_ptr_q[7:0] : stack_top_ptr_q[15:8];
				end
			end else begin
				if (acc_addr <= DS_IO_LAST) begin
					io_d = '{addr: ioa, wdata: regs_q[acc_reg], we: acc_wr, re: acc_rd}; // RULE10
				end else begin
					bus_d = '{addr: acc_addr, wdata: regs_q[acc_reg], we: acc_wr, re: acc_rd}; // RULE11
				end
				if (acc_rd) begin
					ld_reg_d        = acc_reg;
					ld_io_d         = (acc_addr <= DS_IO_LAST);
					fetch_address_d = fetch_address_q;
					state_d         = ST_LOAD_A;
				end
			end
		end
	end

	// register file: per-entry byte port plus pointer pair port
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				regs_q[i] <= 8'h00;
			end else if (wr_en && wr_idx == 5'(i)) begin
				regs_q[i] <= wr_data; // RULE2 RULE3
			end else if (ptr_en && ptr_wr_idx[4:1] == 4'(i / 2)) begin
				regs_q[i] <= (i % 2 == 0) ? ptr_wr_val[7:0] : ptr_wr_val[15:8]; // RULE4
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= FLAGS_RESET; // RULE24
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_q         <= ST_EXEC;
			fetch_address_q <= FETCH_RESET;
			valid_q         <= 1'b0;
			stack_top_ptr_q <= STACK_RESET;
			hold_q          <= 16'h0000;
			target_q        <= 16'h0000;
			ret_q           <= 16'h0000;
			pop_hi_q        <= 8'h00;
			ld_reg_q        <= 5'h00;
			ld_io_q         <= 1'b0;
			iret_q          <= 1'b0;
			lpm_lo_q        <= 1'b0;
		end else begin
			state_q         <= state_d;
			fetch_address_q <= fetch_address_d;
			valid_q         <= valid_d;
			stack_top_ptr_q <= stack_top_ptr_d;
			hold_q          <= hold_d;
			target_q        <= target_d;
			ret_q           <= ret_d;
			pop_hi_q        <= pop_hi_d;
			ld_reg_q        <= ld_reg_d;
			ld_io_q         <= ld_io_d;
			iret_q          <= iret_d;
			lpm_lo_q        <= lpm_lo_d;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_q    <= '0;
			io_q     <= '0;
			ack_q    <= 1'b0;
			ack_id_q <= 3'h0;
		end else begin
			bus_q    <= bus_d;
			io_q     <= io_d;
			ack_q    <= ack_d;
			ack_id_q <= ack_id_d;
		end
	end
endmodule : core_top

/* File: verification/core_top_chk.sv */
module core_top_chk import core_pkg::*; (
	input wire logic               core_clk,            // clock
	input wire logic               rstn,                // reset, active low
	input wire logic [15:0]        prog_addr,           // fetch address
	input wire bus_t               data_bus,            // data access
	input wire io_t                io_bus,              // io access
	input wire logic [NUM_IRQ-1:0] irq_req,             // requests
	input wire logic               irq_ack,             // accept pulse
	input wire logic [2:0]         irq_ack_id,          // accepted index
	input wire flags_t             alu_condition_flags, // status
	input wire logic [15:0]        stack_top_ptr        // stack pointer
);
	timeunit 1ns;
	timeprecision 1ps;
	flags_t fl;
	assign fl = alu_condition_flags;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	function automatic logic [2:0] low_id(logic [NUM_IRQ-1:0] r);
		low_id = 3'h0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) if (r[i]) low_id = 3'(i);
	endfunction : low_id
	// two stack writes, second one byte lower
	sequence push_pair_s;
		data_bus.we ##1 data_bus.we && data_bus.addr == $past(data_bus.addr) - 16'h0001;
	endsequence
	sign_xor_a: assert property (fl.polarity == (fl.top ^ fl.twoc))
		else $error("sign flag wrong");
	flags_zero_a: assert property ($rose(rstn) |-> fl == FLAGS_RESET)
		else $error("flags not clear after reset");
	gie_gate_a: assert property ($rose(irq_ack) |-> $past(fl.gie) && !fl.gie)
		else $error("interrupt taken without enable");
	ack_clear_a: assert property (irq_ack |=> !irq_ack && !fl.gie)
		else $error("enable back too early");
	prio_pick_a: assert property (irq_ack |-> irq_ack_id == low_id($past(irq_req)))
		else $error("wrong interrupt picked");
	push_ret_a: assert property (irq_ack |-> push_pair_s)
		else $error("return address not pushed");
	vec_jump_a: assert property (irq_ack |-> ##2 prog_addr == VEC_BASE + VEC_STRIDE * (16'(irq_ack_id) + 16'h0001))
		else $error("wrong vector");
	sp_drop_a: assert property (irq_ack ##1 data_bus.we |-> ##2 stack_top_ptr == $past(data_bus.addr, 2) - 16'h0001)
		else $error("stack pointer not lowered by two");
	ext_only_a: assert property (data_bus.we || data_bus.re |-> data_bus.addr >= DS_EXT_FIRST)
		else $error("low data address on external bus");
	io_inside_a: assert property (io_bus.we || io_bus.re |-> io_bus.addr < IO_STACK_LO)
		else $error("internal io address on bus");
endmodule : core_top_chk

bind core_top core_top_chk chk (.core_clk, .rstn, .prog_addr, .data_bus, .io_bus, .irq_req, .irq_ack, .irq_ack_id,
	.alu_condition_flags, .stack_top_ptr);

/* File: verification/mem_model.sv */
module mem_model import core_pkg::*; (
	input  wire logic        core_clk,   // clock
	input  wire logic [15:0] prog_addr,  // fetch address
	output logic [15:0]      prog_data,  // word one edge later
	input  wire bus_t        data_bus,   // data access
	output logic [7:0]       data_rdata, // read data
	input  wire io_t         io_bus,     // io access
	output logic [7:0]       io_rdata    // io read data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rom [256];
	logic [7:0]  ram [2048];
	logic [13:0] io_log [$];
	initial {data_rdata, io_rdata} = 16'h5aa5;
	// idle read lines toggle so stale data never looks valid
	always @(posedge core_clk) begin
		prog_data <= rom[prog_addr[7:0]];
		data_rdata <= data_bus.re ? ram[data_bus.addr[10:0]] : ~data_rdata;
		io_rdata <= ~io_rdata;
		if (data_bus.we) ram[data_bus.addr[10:0]] <= data_bus.wdata;
		if (io_bus.we) io_log.push_back({io_bus.addr, io_bus.wdata});
	end
endmodule : mem_model

/* File: verification/tb_top.sv */
module tb_top import core_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] OPS [10] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_EOR, OP_SUBI, OP_ANDI, OP_ORI};
	logic        core_clk = 1'b0, rstn = 1'b0, irq_ack;
	logic [7:0]  irq_req = 8'h28, data_rdata, io_rdata, res;
	logic [15:0] prog_addr, prog_data, stack_top_ptr, lp;
	logic [2:0]  irq_ack_id;
	bus_t        data_bus;
	io_t         io_bus;
	flags_t      alu_condition_flags;
	int          err_total = 0, checks = 0, pc = 0, acks = 0;
	logic [21:0] exp_q [$];
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) if (irq_ack === 1'b1) acks <= acks + 1;
	core_top uut (.core_clk, .rstn, .prog_addr, .prog_data, .data_bus, .data_rdata, .io_bus, .io_rdata, .irq_req,
		.irq_ack, .irq_ack_id, .alu_condition_flags, .stack_top_ptr);
	mem_model mem (.core_clk, .prog_addr, .prog_data, .data_bus, .data_rdata, .io_bus, .io_rdata);
	task automatic check(string what, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	task automatic put(logic [15:0] w);
		mem.rom[pc] = w;
		pc++;
	endtask : put
	function automatic logic [15:0] rr(logic [3:0] o, logic [4:0] d, s); return {o, 2'b00, s, d}; endfunction : rr
	function automatic logic [15:0] im(logic [3:0] o, logic [4:0] d, logic [7:0] k);
		return {o, k[7:4], d[3:0], k[3:0]};
	endfunction : im
	function automatic logic [15:0] io_op(logic o, logic [5:0] a, logic [4:0] r); return {4'hf, o, a, r}; endfunction : io_op
	function automatic logic [23:0] alu_exp(logic [3:0] op, logic [7:0] a, b, logic c, z);
		logic [8:0] r;
		logic       v, h;
		logic [7:0] m;
		h = 1'b0;
		c = c && (op == OP_ADC || op == OP_SBC);
		m = 8'hff;
		case (op)
			OP_ADD, OP_ADC: begin
				r = a + b + c;
				h = ({1'b0, a[3:0]} + b[3:0] + c) > 5'h0f;
				v = a[7] == b[7] && r[7] != a[7];
			end
			OP_SUB, OP_SBC, OP_SUBI: begin
				r = a - b - c;
				h = ({1'b0, a[3:0]} - b[3:0] - c) > 5'h0f;
				v = a[7] != b[7] && r[7] != a[7];
			end
			default: begin
				r = {1'b0, op == OP_EOR ? a ^ b : (op == OP_OR || op == OP_ORI) ? a | b : a & b};
				v = 1'b0;
				m = 8'hde;
			end
		endcase
		z = r[7:0] == 8'h00 && (op != OP_SBC || z);
		return {r[7:0], 8'({h, r[7] ^ v, v, r[7], z, r[8]}) & m, m};
	endfunction : alu_exp
	task automatic wait_ack(logic [2:0] id);
		int t = 0;
		while (irq_ack !== 1'b1 && t < 300) begin
			@(negedge core_clk);
			t++;
		end
		check("ack id", {13'h0, id}, {13'h0, irq_ack_id});
		check("gie on ack", 16'h0, {15'h0, alu_condition_flags.gie});
		if (t == 300) begin
			err_total++;
			summarize();
		end
		@(negedge core_clk);
	endtask : wait_ack
	initial begin
		logic [7:0]  a, b, k;
		logic [3:0]  op;
		logic [23:0] e;
		void'($urandom(38689));
		foreach (mem.rom[i]) mem.rom[i] = 16'h0000;
		put(16'h0500);
		put(16'h0020);
		for (int i = 0; i < NUM_IRQ; i++) begin
			put(rr(OP_SUB, 5'd20, 5'd20));
			put(16'h0400);
		end
		pc = 32;
		put(im(OP_LDI, 5'd21, 8'hf0));
		put(io_op(1'b1, IO_STACK_LO, 5'd21));
		put(im(OP_LDI, 5'd21, 8'h04));
		put(io_op(1'b1, IO_STACK_HI, 5'd21));
		for (int i = 0; i < 24; i++) begin
			op = OPS[i % 10];
			a = i < 10 ? (i[0] ? 8'h80 : 8'h7f) : 8'($urandom);
			b = i < 10 ? (i[1] ? a : 8'h01) : 8'($urandom);
			k = i < 10 ? {8{i[2]}} : 8'($urandom);
			put(im(OP_LDI, 5'd16, a));
			put(im(OP_LDI, 5'd17, b));
			put(im(OP_LDI, 5'd18, k));
			put(rr(OP_CP, 5'd18, 5'd17));
			put(op >= OP_SUBI ? im(op, 5'd16, b) : rr(op, 5'd16, 5'd17));
			put(io_op(1'b0, IO_FLAGS, 5'd19));
			put(io_op(1'b1, 6'h01, 5'd16));
			put(io_op(1'b1, 6'h02, 5'd19));
			e = alu_exp(op, a, b, k < b, k == b);
			exp_q.push_back({6'h01, e[23:16], 8'hff});
			exp_q.push_back({6'h02, e[15:0]});
		end
		res = e[23:16];
		put(16'h0810);
		put(16'h0080);
		put(16'h0a55);
		put(16'h0b15);
		put(16'h0815);
		put(16'h0021);
		exp_q.push_back({6'h01, 8'h05, 8'hff});
		put(16'h0100);
		lp = 16'(pc);
		put(16'he7ff);
		repeat (16) @(negedge core_clk);
		rstn = 1'b1;
		for (int t = 0; t < 3000 && mem.io_log.size() < exp_q.size(); t++) @(negedge core_clk);
		check("ack before enable", 16'h0, 16'(acks));
		check("io writes", 16'(exp_q.size()), 16'(mem.io_log.size()));
		if (mem.io_log.size() < exp_q.size()) summarize();
		for (int i = 0; i < exp_q.size(); i++) begin
			e = {2'b00, exp_q[i]};
			check("io write", {2'b00, e[21:8]}, {2'b00, mem.io_log[i] & {6'h3f, e[7:0]}});
		end
		wait_ack(3'h3);
		irq_req = 8'h20;
		wait_ack(3'h5);
		irq_req = 8'h00;
		repeat (30) @(negedge core_clk);
		check("ext store", {8'h00, res}, {8'h00, mem.ram[11'h080]});
		check("ret low", {8'h00, lp[7:0]}, {8'h00, mem.ram[11'h4f0]});
		check("ret high", {8'h00, lp[15:8]}, {8'h00, mem.ram[11'h4ef]});
		check("sp back", 16'h04f0, stack_top_ptr);
		check("flags kept", 16'h00c2, {8'h00, alu_condition_flags});
		summarize();
	end
endmodule : tb_top
